// file: inc/ghk_pkg.sv
package ghk_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int PIN_N = 24;
    localparam int SRC_N = 9;
    // Register byte addresses
    localparam logic [7:0] CFG_HI_ADDR = 8'h10;
    localparam logic [7:0] CFG_LO_ADDR = 8'h11;
    localparam logic [7:0] SRC_EN_HI_ADDR = 8'h12;
    localparam logic [7:0] SRC_EN_LO_ADDR = 8'h13;
    localparam logic [7:0] SRC_FLAG_HI_ADDR = 8'h14;
    localparam logic [7:0] SRC_FLAG_LO_ADDR = 8'h15;
    localparam logic [7:0] PIN_EN_HI_ADDR = 8'h16;
    localparam logic [7:0] PIN_EN_MID_ADDR = 8'h17;
    localparam logic [7:0] PIN_EN_LO_ADDR = 8'h18;
    localparam logic [7:0] PIN_FLAG_HI_ADDR = 8'h19;
    localparam logic [7:0] PIN_FLAG_MID_ADDR = 8'h1a;
    localparam logic [7:0] PIN_FLAG_LO_ADDR = 8'h1b;
    // Control field positions
    localparam int CFG_GLOBAL_EN_BIT = 0;
    localparam int CFG_EDGE_BIT = 1;
    localparam int CFG_POL_BIT = 2;
    localparam int GPIO_SRC_BIT = 8;
    localparam logic [2:0] CFG_RESET = 3'h0;
    localparam logic [8:0] SRC_EN_RESET = 9'h000;
    localparam logic [23:0] PIN_EN_RESET = 24'h000000;
    // Edge pulse width
    localparam int CLK_PERIOD_NS = 40;
    localparam int EDGE_PULSE_NS = 250;
    localparam int EDGE_PULSE_CYC = EDGE_PULSE_NS / CLK_PERIOD_NS;
    localparam int PULSE_CNT_W = 4;
endpackage

// file: hw/ghk_byte_flag.sv
`timescale 1ns/1ns
// One byte of sticky flags: set by events, write-one-to-clear, set wins
module ghk_byte_flag (
    input wire logic core_clk_in, // Clock
    input wire logic rstn_in, // Async reset, active low
    input wire logic [7:0] event_in, // Set pulses
    input wire logic clr_wr_in, // Write strobe to this byte
    input wire logic [7:0] clr_data_in, // Ones clear
    output logic [7:0] flag_out // Sticky flags
);
    logic [7:0] flag_reg;
    logic [7:0] flag_next;
    wire logic [7:0] clr_mask = clr_wr_in ? clr_data_in : 8'h00;

    assign flag_next = (flag_reg & ~clr_mask) | event_in;
    assign flag_out = flag_reg;

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            flag_reg <= 8'h00;
        end else begin
            flag_reg <= flag_next;
        end
    end
endmodule

// file: hw/ghk_irq_out.sv
`timescale 1ns/1ns
// Host interrupt pin shaper: level or fixed-width pulse, selectable polarity
module ghk_irq_out (
    input wire logic core_clk_in, // Clock
    input wire logic rstn_in, // Async reset, active low
    input wire logic req_in, // Qualified pending request
    input wire logic edge_mode_in, // 1 = pulse output
    input wire logic active_high_in, // 1 = active high
    output logic irq_out // Host interrupt level
);
    logic req_d_reg;
    logic [ghk_pkg::PULSE_CNT_W-1:0] cnt_reg;
    logic [ghk_pkg::PULSE_CNT_W-1:0] cnt_next;
    logic irq_reg;
    logic irq_next;
    wire logic rise = req_in & ~req_d_reg;
    wire logic active = edge_mode_in ? (cnt_next != '0) : req_in;
    localparam logic [ghk_pkg::PULSE_CNT_W-1:0] PULSE_LEN =
        ghk_pkg::PULSE_CNT_W'(ghk_pkg::EDGE_PULSE_CYC);

    // One pulse per new request; a held request does not retrigger
    assign cnt_next = rise ? PULSE_LEN : ((cnt_reg != '0) ? cnt_reg - 1'b1 : cnt_reg);
    assign irq_next = active_high_in ? active : ~active;
    assign irq_out = irq_reg;

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            req_d_reg <= 1'b0;
            cnt_reg <= '0;
            irq_reg <= 1'b1;
        end else begin
            req_d_reg <= req_in;
            cnt_reg <= cnt_next;
            irq_reg <= irq_next;
        end
    end
endmodule

// file: hw/ghk_top.sv
`timescale 1ns/1ns
module ghk_top (
    input wire logic core_clk_in, // Clock, 25 MHz
    input wire logic rstn_in, // Async reset, active low
    input wire logic [7:0] reg_addr_in, // Register byte address
    input wire logic reg_wr_in, // Write strobe, one cycle
    input wire logic reg_rd_in, // Read strobe, one cycle
    input wire logic [7:0] reg_wdata_in, // Write data
    input wire logic [23:0] pin_event_in, // Per-pin trigger pulses
    input wire logic [7:0] src_event_in, // Other source trigger pulses
    output logic [7:0] reg_rdata_out, // Read data, registered
    output logic irq_out // Host interrupt pin level
);
    logic [2:0] cfg_reg;
    logic [8:0] src_en_reg;
    logic [23:0] pin_en_reg;
    logic [8:0] src_flag_reg;
    logic [8:0] src_flag_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    wire logic [23:0] pin_flag;
    logic irq_pin;

    wire logic wr_cfg_lsb = reg_wr_in && (reg_addr_in == ghk_pkg::CFG_LO_ADDR);
    wire logic wr_en_msb = reg_wr_in && (reg_addr_in == ghk_pkg::SRC_EN_HI_ADDR);
    wire logic wr_en_lsb = reg_wr_in && (reg_addr_in == ghk_pkg::SRC_EN_LO_ADDR);
    wire logic wr_flag_msb = reg_wr_in && (reg_addr_in == ghk_pkg::SRC_FLAG_HI_ADDR);
    wire logic wr_flag_lsb = reg_wr_in && (reg_addr_in == ghk_pkg::SRC_FLAG_LO_ADDR);
    wire logic [2:0] wr_pin_en;
    wire logic [2:0] wr_pin_flag;
    assign wr_pin_en[2] = reg_wr_in && (reg_addr_in == ghk_pkg::PIN_EN_HI_ADDR);
    assign wr_pin_en[1] = reg_wr_in && (reg_addr_in == ghk_pkg::PIN_EN_MID_ADDR);
    assign wr_pin_en[0] = reg_wr_in && (reg_addr_in == ghk_pkg::PIN_EN_LO_ADDR);
    assign wr_pin_flag[2] = reg_wr_in && (reg_addr_in == ghk_pkg::PIN_FLAG_HI_ADDR);
    assign wr_pin_flag[1] = reg_wr_in && (reg_addr_in == ghk_pkg::PIN_FLAG_MID_ADDR);
    assign wr_pin_flag[0] = reg_wr_in && (reg_addr_in == ghk_pkg::PIN_FLAG_LO_ADDR);

    // Pin flags, one byte per instance
    genvar gi;
    for (gi = 0; gi < 3; gi++) begin : g_pin
        ghk_byte_flag u_flag (
            .core_clk_in(core_clk_in),
            .rstn_in(rstn_in),
            .event_in(pin_event_in[gi*8 +: 8]),
            .clr_wr_in(wr_pin_flag[gi]),
            .clr_data_in(reg_wdata_in),
            .flag_out(pin_flag[gi*8 +: 8])
        );
    end

    // Summary re-sets while an enabled pin flag remains, so clear pin first
    wire logic gpio_pending = |(pin_flag & pin_en_reg);
    wire logic [8:0] src_set = {gpio_pending, src_event_in};
    wire logic [8:0] src_clr = {wr_flag_msb ? reg_wdata_in[0] : 1'b0,
                                wr_flag_lsb ? reg_wdata_in : 8'h00};
    assign src_flag_next = (src_flag_reg & ~src_clr) | src_set;

    wire logic irq_req = cfg_reg[ghk_pkg::CFG_GLOBAL_EN_BIT]
                         && |(src_flag_reg & src_en_reg);

    always_comb begin
        rdata_next = 8'h00;
        if (reg_addr_in == ghk_pkg::CFG_LO_ADDR) begin
            rdata_next = {5'h00, cfg_reg};
        end else if (reg_addr_in == ghk_pkg::SRC_EN_HI_ADDR) begin
            rdata_next = {7'h00, src_en_reg[8]};
        end else if (reg_addr_in == ghk_pkg::SRC_EN_LO_ADDR) begin
            rdata_next = src_en_reg[7:0];
        end else if (reg_addr_in == ghk_pkg::SRC_FLAG_HI_ADDR) begin
            rdata_next = {7'h00, src_flag_reg[8]};
        end else if (reg_addr_in == ghk_pkg::SRC_FLAG_LO_ADDR) begin
            rdata_next = src_flag_reg[7:0];
        end else if (reg_addr_in == ghk_pkg::PIN_EN_HI_ADDR) begin
            rdata_next = pin_en_reg[23:16];
        end else if (reg_addr_in == ghk_pkg::PIN_EN_MID_ADDR) begin
            rdata_next = pin_en_reg[15:8];
        end else if (reg_addr_in == ghk_pkg::PIN_EN_LO_ADDR) begin
            rdata_next = pin_en_reg[7:0];
        end else if (reg_addr_in == ghk_pkg::PIN_FLAG_HI_ADDR) begin
            rdata_next = pin_flag[23:16];
        end else if (reg_addr_in == ghk_pkg::PIN_FLAG_MID_ADDR) begin
            rdata_next = pin_flag[15:8];
        end else if (reg_addr_in == ghk_pkg::PIN_FLAG_LO_ADDR) begin
            rdata_next = pin_flag[7:0];
        end
    end

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rdata_reg <= 8'h00;
        end else if (reg_rd_in) begin
            rdata_reg <= rdata_next;
        end
    end

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cfg_reg <= ghk_pkg::CFG_RESET;
        end else if (wr_cfg_lsb) begin
            cfg_reg <= reg_wdata_in[2:0];
        end
    end

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            src_en_reg <= ghk_pkg::SRC_EN_RESET;
        end else if (wr_en_msb) begin
            src_en_reg[8] <= reg_wdata_in[0];
        end else if (wr_en_lsb) begin
            src_en_reg[7:0] <= reg_wdata_in;
        end
    end

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pin_en_reg <= ghk_pkg::PIN_EN_RESET;
        end else begin
            if (wr_pin_en[2]) begin
                pin_en_reg[23:16] <= reg_wdata_in;
            end
            if (wr_pin_en[1]) begin
                pin_en_reg[15:8] <= reg_wdata_in;
            end
            if (wr_pin_en[0]) begin
                pin_en_reg[7:0] <= reg_wdata_in;
            end
        end
    end

    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            src_flag_reg <= 9'h000;
        end else begin
            src_flag_reg <= src_flag_next;
        end
    end

    ghk_irq_out u_irq (
        .core_clk_in(core_clk_in),
        .rstn_in(rstn_in),
        .req_in(irq_req),
        .edge_mode_in(cfg_reg[ghk_pkg::CFG_EDGE_BIT]),
        .active_high_in(cfg_reg[ghk_pkg::CFG_POL_BIT]),
        .irq_out(irq_pin)
    );

    assign reg_rdata_out = rdata_reg;
    assign irq_out = irq_pin;
endmodule

// file: test/ghk_top_sva.sv
`timescale 1ns/1ns
module ghk_top_sva (
    input wire logic core_clk_in, // Clock
    input wire logic rstn_in, // Reset, active low
    input wire logic [7:0] reg_addr_in, // Address
    input wire logic reg_wr_in, // Write strobe
    input wire logic reg_rd_in, // Read strobe
    input wire logic [7:0] reg_wdata_in, // Write data
    input wire logic [23:0] pin_event_in, // Pin events
    input wire logic [7:0] src_event_in, // Source events
    input wire logic [7:0] reg_rdata_out, // Read data
    input wire logic irq_out // Host interrupt
);
    logic [2:0] cfg_reg;
    logic [8:0] sen_reg;
    logic [3:0] cnt_reg;
    // Mode checks wait until config and source enables have settled
    wire cfg_wr = reg_wr_in && reg_addr_in inside {[8'h11:8'h13]};
    wire quiet = cnt_reg >= 4'h8;
    wire act = irq_out == cfg_reg[2];
    always_ff @(posedge core_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cfg_reg <= 3'h0;
            sen_reg <= 9'h000;
            cnt_reg <= 4'h0;
        end else begin
            if (reg_wr_in && reg_addr_in == 8'h11) cfg_reg <= reg_wdata_in[2:0];
            if (reg_wr_in && reg_addr_in == 8'h12) sen_reg[8] <= reg_wdata_in[0];
            if (reg_wr_in && reg_addr_in == 8'h13) sen_reg[7:0] <= reg_wdata_in;
            cnt_reg <= cfg_wr ? 4'h0 : (quiet ? cnt_reg : cnt_reg + 4'h1);
        end
    end
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!rstn_in);
    unmapped_zero_a: assert property (reg_rd_in && (reg_addr_in < 8'h11 ||
        reg_addr_in > 8'h1b) |=> reg_rdata_out == 8'h00) else $error("unmapped read not zero");
    rdata_hold_a: assert property (!reg_rd_in |=> $stable(reg_rdata_out))
        else $error("read data moved");
    enable_back_a: assert property (reg_wr_in && reg_addr_in == 8'h17 ##1 reg_rd_in &&
        reg_addr_in == 8'h17 |=> reg_rdata_out == $past(reg_wdata_in, 2))
        else $error("pin enable readback");
    flag_set_a: assert property (reg_rd_in && reg_addr_in == 8'h1b && !$past(reg_wr_in)
        |=> (reg_rdata_out & $past(pin_event_in[7:0], 2)) == $past(pin_event_in[7:0], 2))
        else $error("pin flag not set");
    flag_clear_a: assert property (reg_wr_in && reg_addr_in == 8'h1b && pin_event_in[7:0] ==
        8'h00 ##1 reg_rd_in && reg_addr_in == 8'h1b |=> (reg_rdata_out & $past(reg_wdata_in, 2))
        == 8'h00) else $error("pin flag not cleared");
    level_raise_a: assert property (!cfg_reg[1] && cfg_reg[0] && quiet && !reg_wr_in &&
        (src_event_in & sen_reg[7:0]) != 8'h00 |-> ##2 act) else $error("irq not raised");
    level_hold_a: assert property (!cfg_reg[1] && quiet && act && !reg_wr_in &&
        !$past(reg_wr_in) |=> act) else $error("level irq dropped");
    blocked_a: assert property (quiet && (!cfg_reg[0] || sen_reg == 9'h000) |-> !act)
        else $error("irq active while blocked");
    edge_pulse_a: assert property (cfg_reg[1] && quiet && $rose(act) |-> act [*6] ##1 !act)
        else $error("edge pulse width");
endmodule

bind ghk_top ghk_top_sva chk_u (.core_clk_in(core_clk_in), .rstn_in(rstn_in),
    .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_wdata_in(reg_wdata_in), .pin_event_in(pin_event_in), .src_event_in(src_event_in),
    .reg_rdata_out(reg_rdata_out), .irq_out(irq_out));

// file: test/ghk_host_model.sv
`timescale 1ns/1ns
// Host side of the register bus: one strobe per edge, held until idle
module ghk_host_model (
    input wire logic clk_in, // Clock
    output logic [7:0] addr_out, // Address
    output logic wr_out, // Write strobe
    output logic rd_out, // Read strobe
    output logic [7:0] wdata_out // Write data
);
    initial begin
        addr_out = 8'h00;
        wr_out = 1'b0;
        rd_out = 1'b0;
        wdata_out = 8'h00;
    end
    task automatic op(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        wr_out <= w;
        rd_out <= !w;
        addr_out <= a;
        wdata_out <= d;
    endtask
    // Released bus shows no stale address or data
    task automatic idle();
        @(posedge clk_in);
        wr_out <= 1'b0;
        rd_out <= 1'b0;
        addr_out <= ~addr_out;
        wdata_out <= ~wdata_out;
    endtask
endmodule

// file: test/ghk_top_tb.sv
`timescale 1ns/1ns
module ghk_top_tb;
    logic core_clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic [23:0] pin_event_in = 24'h000000;
    logic [7:0] src_event_in = 8'h00;
    logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out;
    logic reg_wr_in, reg_rd_in, irq_out;
    logic [7:0] exp_q[$];
    logic [23:0] en, v;
    int error_cnt = 0;
    int checks = 0;
    int n;
    initial forever #20 core_clk_in = ~core_clk_in;
    ghk_host_model host_u (.clk_in(core_clk_in), .addr_out(reg_addr_in), .wr_out(reg_wr_in),
        .rd_out(reg_rd_in), .wdata_out(reg_wdata_in));
    ghk_top dut_u (.core_clk_in(core_clk_in), .rstn_in(rstn_in), .reg_addr_in(reg_addr_in),
        .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in),
        .pin_event_in(pin_event_in), .src_event_in(src_event_in),
        .reg_rdata_out(reg_rdata_out), .irq_out(irq_out));
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
        checks++;
        if (s !== e) begin
            error_cnt++;
            $display("[FAIL] %s exp %h got %h", nm, e, s);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        host_u.op(1'b0, a, 8'h00);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host_u.op(1'b1, a, d);
    endtask
    task automatic ci(input logic e);
        @(negedge core_clk_in);
        chk("irq_out", {7'h00, e}, {7'h00, irq_out});
    endtask
    task automatic pulse(input logic [23:0] p, input logic [7:0] s);
        @(posedge core_clk_in);
        pin_event_in <= p;
        src_event_in <= s;
        @(posedge core_clk_in);
        pin_event_in <= 24'h000000;
        src_event_in <= 8'h00;
    endtask
    // Read data lands on the edge that takes the strobe
    always begin
        @(posedge core_clk_in);
        if (reg_rd_in === 1'b1) begin
            @(negedge core_clk_in);
            chk("reg_rdata_out", exp_q.pop_front(), reg_rdata_out);
        end
    end
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // Tests need under a thousand cycles
    initial begin
        repeat (20000) @(posedge core_clk_in);
        error_cnt++;
        final_report();
    end
    initial begin
        void'($urandom(45318));
        repeat (16) @(posedge core_clk_in);
        rstn_in <= 1'b1;
        ci(1'b1);
        for (int a = 16; a <= 28; a++) rd(8'(a), 8'h00);
        wr(8'h10, 8'hff);
        rd(8'h10, 8'h00);
        rd(8'hff, 8'h00);
        en = 24'($urandom);
        for (int i = 0; i < 3; i++) begin
            wr(8'(22 + i), en[23 - 8 * i -: 8]);
            rd(8'(22 + i), en[23 - 8 * i -: 8]);
        end
        host_u.idle();
        $display("map and enables done");
        v = 24'($urandom);
        @(posedge core_clk_in);
        pin_event_in <= v;
        rd(8'h1b, v[7:0]);
        pin_event_in <= 24'h000000;
        rd(8'h1a, v[15:8]);
        rd(8'h19, v[23:16]);
        rd(8'h14, {7'h00, |(v & en)});
        n = $urandom;
        wr(8'h1b, n[7:0]);
        rd(8'h1b, v[7:0] & ~n[7:0]);
        $display("pin flags done");
        for (int i = 0; i < 3; i++) wr(8'(22 + i), {7'h00, i == 2});
        for (int i = 0; i < 3; i++) wr(8'(25 + i), 8'hff);
        wr(8'h14, 8'h01);
        wr(8'h12, 8'h01);
        wr(8'h11, 8'h01);
        host_u.idle();
        repeat (10) @(posedge core_clk_in);
        // Unused pins stay quiet, as outputs set by the host would
        pulse(24'h000001, 8'h00);
        repeat (2) begin
            repeat (6) @(posedge core_clk_in);
            ci(1'b0);
        end
        rd(8'h14, 8'h01);
        rd(8'h1b, 8'h01);
        wr(8'h1b, 8'h01);
        wr(8'h14, 8'h01);
        host_u.idle();
        repeat (3) @(posedge core_clk_in);
        ci(1'b1);
        wr(8'h11, 8'h00);
        rd(8'h12, 8'h01);
        host_u.idle();
        pulse(24'h000001, 8'h00);
        repeat (4) @(posedge core_clk_in);
        ci(1'b1);
        wr(8'h1b, 8'h01);
        wr(8'h14, 8'h01);
        $display("gpio interrupt done");
        for (int m = 0; m < 4; m++) begin
            wr(8'h11, {5'h00, m[1], m[0], 1'b1});
            wr(8'h13, 8'hff);
            host_u.idle();
            repeat (10) @(posedge core_clk_in);
            pulse(24'h000000, 8'h01 << $urandom_range(7));
            n = 0;
            repeat (20) begin
                @(negedge core_clk_in);
                n += (irq_out === m[1]);
            end
            chk("active cycles", m[0] ? 8'(ghk_pkg::EDGE_PULSE_CYC) : 8'h13, 8'(n));
            wr(8'h15, 8'hff);
            host_u.idle();
            repeat (3) @(posedge core_clk_in);
            ci(!m[1]);
        end
        $display("output modes done");
        final_report();
    end
endmodule
